// ===== rtl/eeprom_loader_cfg.svh
// Offsets, field positions, reset values and timing counts of the EEPROM loader
`ifndef EEPROM_LOADER_CFG_SVH
`define EEPROM_LOADER_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CFG_CLK_PERIOD_NS 20
`define CFG_SK_HALF_NS    80
`define CFG_SK_HALF_CYC   ((`CFG_SK_HALF_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

// ****************************************************************
// Serial command
// ****************************************************************
`define CFG_READ_CMD   3'h6
`define CFG_CMD_BITS   3
`define CFG_WORD_BITS  16

// ****************************************************************
// Byte map
// ****************************************************************
`define CFG_PTR_RESET  9'h000
`define CFG_DEF_LAST   9'h01B
`define CFG_ID_FIRST   9'h01C
`define CFG_ID_LAST    9'h024
`define CFG_RES_FIRST  9'h025
`define CFG_DEF_COUNT  28
`define CFG_ID_BYTES   9

// ****************************************************************
// Default byte indices and fields
// ****************************************************************
`define CFG_B_MODE     0
`define CFG_B_WA_BLO   1
`define CFG_B_WA_BHI   2
`define CFG_B_WA_CTL   3
`define CFG_B_WA_HLO   4
`define CFG_B_WA_HHI   5
`define CFG_B_WB_BLO   6
`define CFG_B_WB_BHI   7
`define CFG_B_ACT      27
`define CFG_MODE_BIT   0
`define CFG_SUB_LSB    1
`define CFG_WIDE_BIT   1
`define CFG_AEN_BIT    2
`define CFG_DMA_LSB    4
`define CFG_DMA_NONE   3'h4
`define CFG_DMA_BAD1   3'h1
`define CFG_DMA_BAD2   3'h2
`define CFG_ACT_BITS   4

`endif

// ===== rtl/eeprom_loader_pkg.sv
// Types shared by the EEPROM configuration loader
package eeprom_loader_pkg;

  typedef struct packed {
    logic        memMode;
    logic [1:0]  submode;
    logic [15:0] memorySelectWindowABase;
    logic [15:0] memorySelectWindowAHigh;
    logic        memorySelectWindowAWide;
    logic        memorySelectWindowAAen;
    logic [15:0] memorySelectWindowBBase;
    logic        dmaChannelASelectValid;
    logic        dmaChannelASelectNone;
    logic [2:0]  dmaChannelASelect;
  } cfg_decode_t;

  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_CMD  = 4'h2,
    RD_DATA = 4'h4,
    RD_GAP  = 4'h8
  } reader_state_t;

  typedef enum logic [4:0] {
    LD_BOOT   = 5'h01,
    LD_DECODE = 5'h02,
    LD_IDLE   = 5'h04,
    LD_IDFILL = 5'h08,
    LD_RESGET = 5'h10
  } loader_state_t;

endpackage

// ===== rtl/eeprom_word_reader.sv
// Four-wire serial EEPROM single-word read engine
`timescale 1ns/10ps
`include "eeprom_loader_cfg.svh"

module eeprom_word_reader #(
  parameter int ADDR_BITS = 8
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Request side
  input  wire logic                 start,
  input  wire logic [ADDR_BITS-1:0] wordAddr,
  output logic                      busy,
  output logic                      done,
  output logic [15:0]               wordData,
  // Serial pins
  output logic                      eeCs,
  output logic                      eeSk,
  output logic                      eeDi,
  input  wire logic                 eeDo
);

  localparam int CMD_BITS = `CFG_CMD_BITS + ADDR_BITS;
  localparam logic [7:0] HALF_LAST = 8'(`CFG_SK_HALF_CYC - 1);

  eeprom_loader_pkg::reader_state_t state_reg, state_next;
  logic [7:0]          div_reg, div_next;
  logic [4:0]          bit_reg, bit_next;
  logic [CMD_BITS-1:0] shift_reg, shift_next;
  logic [15:0]         data_reg, data_next;
  logic                cs_reg, cs_next, sk_reg, sk_next, di_reg, di_next, done_reg, done_next;
  logic                doMeta_reg, doSync_reg;
  logic                tick, falling;

  assign tick    = (div_reg == HALF_LAST);
  assign falling = tick && sk_reg;

  always_comb begin
    state_next = state_reg;
    div_next   = tick ? 8'h00 : div_reg + 8'h01;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    data_next  = data_reg;
    cs_next    = cs_reg;
    sk_next    = tick ? ~sk_reg : sk_reg;
    di_next    = di_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      eeprom_loader_pkg::RD_IDLE: begin
        div_next = 8'h00;
        sk_next  = 1'b0;
        if (start) begin
          shift_next = {`CFG_READ_CMD, wordAddr} << 1;
          di_next    = 1'b1;
          cs_next    = 1'b1;
          bit_next   = 5'h00;
          state_next = eeprom_loader_pkg::RD_CMD;
        end
      end
      eeprom_loader_pkg::RD_CMD: begin
        if (falling) begin
          if (bit_reg == 5'(CMD_BITS - 1)) begin
            di_next    = 1'b0;
            bit_next   = 5'h00;
            state_next = eeprom_loader_pkg::RD_DATA;
          end else begin
            di_next    = shift_reg[CMD_BITS-1];
            shift_next = shift_reg << 1;
            bit_next   = bit_reg + 5'h01;
          end
        end
      end
      eeprom_loader_pkg::RD_DATA: begin
        // Dummy zero already skipped; sample just before each falling edge
        if (falling) begin
          data_next = {data_reg[14:0], doSync_reg};
          bit_next  = bit_reg + 5'h01;
          if (bit_reg == 5'(`CFG_WORD_BITS - 1)) begin
            cs_next    = 1'b0;
            done_next  = 1'b1;
            state_next = eeprom_loader_pkg::RD_GAP;
          end
        end
      end
      eeprom_loader_pkg::RD_GAP: begin
        // Chip select must stay low a while before the next command
        sk_next = 1'b0;
        if (tick) begin
          state_next = eeprom_loader_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    doMeta_reg <= eeDo;
    doSync_reg <= doMeta_reg;
    if (sys_rst) begin
      state_reg <= eeprom_loader_pkg::RD_IDLE;
      div_reg   <= 8'h00;
      bit_reg   <= 5'h00;
      shift_reg <= '0;
      data_reg  <= 16'h0000;
      cs_reg    <= 1'b0;
      sk_reg    <= 1'b0;
      di_reg    <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      data_reg  <= data_next;
      cs_reg    <= cs_next;
      sk_reg    <= sk_next;
      di_reg    <= di_next;
      done_reg  <= done_next;
    end
  end

  assign busy     = (state_reg != eeprom_loader_pkg::RD_IDLE);
  assign done     = done_reg;
  assign wordData = data_reg;
  assign eeCs     = cs_reg;
  assign eeSk     = sk_reg;
  assign eeDi     = di_reg;

endmodule

// ===== rtl/serial_eeprom_config_loader.sv
// Serial EEPROM configuration loader: defaults, serial identifier, resource data
//
// Notes on behaviour
// - The EEPROM is read over four wires as 16-bit words; both the 128 and 256 word parts work.
// - Every word is stored bit-reversed, so each fetched word is reversed before use.
// - After reset the pointer starts at the first word and bytes 0x000 to 0x01B load the defaults.
// - Entering isolation reads bytes 0x1C to 0x24 into the identifier shift register.
// - The pointer then rests at 0x25 and configuration reads walk resource bytes in order.
// - A nonzero wake number matching this card's number sets the pointer back to 0x1C.
// - Default byte 0 bit 0 picks DMA or memory mode and bits 2:1 the submode.
// - In memory mode bytes 1, 2, 4 and 5 give window A base and upper address bits 23:8.
// - In memory mode byte 3 bit 1 gives window A width and bit 2 AEN participation.
// - In DMA mode byte 3 bits 6:4 select the DMA channel, code 100 none, 001 and 010 invalid.
// - In memory mode bytes 6 and 7 give window B base address bits 23:8.
// - A logical device is active at reset only if the activate pin is low and its bit is set.
`timescale 1ns/10ps
`include "eeprom_loader_cfg.svh"

module serial_eeprom_config_loader #(
  parameter int ADDR_BITS = 8
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // Serial EEPROM pins
  output logic                               eeCs,
  output logic                               eeSk,
  output logic                               eeDi,
  input  wire logic                          eeDo,
  // Strap
  input  wire logic                          activate_at_reset_pin_n,
  // Card state events
  input  wire logic                          reloadReq,
  input  wire logic                          enterIsolation,
  input  wire logic                          wakeValid,
  input  wire logic [7:0]                    wakeCsn,
  input  wire logic [7:0]                    cardCsn,
  input  wire logic                          configState,
  // Resource data port
  input  wire logic                          resTake,
  output logic [7:0]                         resData,
  output logic                               resValid,
  // Loaded configuration
  output logic                               defaultsLoaded,
  output logic [8*`CFG_DEF_COUNT-1:0]        defaultRegs,
  output eeprom_loader_pkg::cfg_decode_t     cfgDecode,
  output logic [`CFG_ACT_BITS-1:0]           deviceActive,
  output logic [8*`CFG_ID_BYTES-1:0]         serialId,
  output logic                               idLoaded,
  output logic [ADDR_BITS:0]                 readPtr
);

  localparam int PTR_W = ADDR_BITS + 1;

  // ****************************************************************
  // Word reader and bit reversal
  // ****************************************************************
  logic                 rdStart, rdBusy, rdDone;
  logic [15:0]          rdWord, revWord;
  logic [ADDR_BITS-1:0] rdAddr;

  eeprom_word_reader #(
    .ADDR_BITS (ADDR_BITS)
  ) u_reader (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (rdStart),
    .wordAddr (rdAddr),
    .busy     (rdBusy),
    .done     (rdDone),
    .wordData (rdWord),
    .eeCs     (eeCs),
    .eeSk     (eeSk),
    .eeDi     (eeDi),
    .eeDo     (eeDo)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_rev
      assign revWord[gi] = rdWord[15-gi];
    end
  endgenerate

  // ****************************************************************
  // One-word cache
  // ****************************************************************
  // Keeps the second byte of a word without a second serial read
  logic [15:0]          cacheWord_reg, cacheWord_next;
  logic [ADDR_BITS-1:0] cacheAddr_reg, cacheAddr_next, reqAddr_reg, reqAddr_next;
  logic                 cacheValid_reg, cacheValid_next;
  logic                 hit;
  logic [7:0]           curByte;

  always_comb begin
    cacheWord_next  = cacheWord_reg;
    cacheAddr_next  = cacheAddr_reg;
    cacheValid_next = cacheValid_reg;
    reqAddr_next    = rdStart ? rdAddr : reqAddr_reg;
    if (rdDone) begin
      cacheWord_next  = revWord;
      cacheAddr_next  = reqAddr_reg;
      cacheValid_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cacheWord_reg  <= 16'h0000;
      cacheAddr_reg  <= '0;
      cacheValid_reg <= 1'b0;
      reqAddr_reg    <= '0;
    end else begin
      cacheWord_reg  <= cacheWord_next;
      cacheAddr_reg  <= cacheAddr_next;
      cacheValid_reg <= cacheValid_next;
      reqAddr_reg    <= reqAddr_next;
    end
  end

  // ****************************************************************
  // Strap synchroniser
  // ****************************************************************
  logic actMeta_reg, actSync_reg;

  always_ff @(posedge core_clk) begin
    actMeta_reg <= activate_at_reset_pin_n;
    actSync_reg <= actMeta_reg;
  end

  // ****************************************************************
  // Loader sequencer
  // ****************************************************************
  eeprom_loader_pkg::loader_state_t state_reg, state_next;
  eeprom_loader_pkg::cfg_decode_t   dec_reg, dec_next;
  logic [PTR_W-1:0]                 ptr_reg, ptr_next;
  logic [7:0]                       defBytes_reg [`CFG_DEF_COUNT];
  logic [7:0]                       defBytes_next [`CFG_DEF_COUNT];
  logic [8*`CFG_ID_BYTES-1:0]       id_reg, id_next;
  logic [7:0]                       res_reg, res_next;
  logic [`CFG_ACT_BITS-1:0]         act_reg, act_next;
  logic                             resValid_reg, resValid_next;
  logic                             loaded_reg, loaded_next, idOk_reg, idOk_next;
  logic                             fetching, consume, wakeMatch;
  logic [2:0]                       dmaCode;

  assign rdAddr    = ptr_reg[PTR_W-1:1];
  assign hit       = cacheValid_reg && (cacheAddr_reg == ptr_reg[PTR_W-1:1]);
  assign curByte   = ptr_reg[0] ? cacheWord_reg[15:8] : cacheWord_reg[7:0];
  assign fetching  = (state_reg == eeprom_loader_pkg::LD_BOOT)
                  || (state_reg == eeprom_loader_pkg::LD_IDFILL)
                  || (state_reg == eeprom_loader_pkg::LD_RESGET);
  assign consume   = fetching && hit;
  assign rdStart   = fetching && !hit && !rdBusy;
  assign wakeMatch = wakeValid && (wakeCsn != 8'h00) && (wakeCsn == cardCsn);
  assign dmaCode   = defBytes_reg[`CFG_B_WA_CTL][`CFG_DMA_LSB +: 3];

  always_comb begin
    state_next    = state_reg;
    ptr_next      = ptr_reg;
    defBytes_next = defBytes_reg;
    id_next       = id_reg;
    res_next      = res_reg;
    act_next      = act_reg;
    dec_next      = dec_reg;
    resValid_next = resValid_reg;
    loaded_next   = loaded_reg;
    idOk_next     = idOk_reg;
    if (resTake) begin
      resValid_next = 1'b0;
    end
    unique case (state_reg)
      eeprom_loader_pkg::LD_BOOT: begin
        if (consume) begin
          defBytes_next[ptr_reg[4:0]] = curByte;
          ptr_next = ptr_reg + PTR_W'(1);
          if (ptr_reg == PTR_W'(`CFG_DEF_LAST)) begin
            state_next = eeprom_loader_pkg::LD_DECODE;
          end
        end
      end
      eeprom_loader_pkg::LD_DECODE: begin
        dec_next = '0;
        dec_next.memMode = defBytes_reg[`CFG_B_MODE][`CFG_MODE_BIT];
        dec_next.submode = defBytes_reg[`CFG_B_MODE][`CFG_SUB_LSB +: 2];
        if (dec_next.memMode) begin
          dec_next.memorySelectWindowABase =
            {defBytes_reg[`CFG_B_WA_BHI], defBytes_reg[`CFG_B_WA_BLO]};
          dec_next.memorySelectWindowAHigh =
            {defBytes_reg[`CFG_B_WA_HHI], defBytes_reg[`CFG_B_WA_HLO]};
          dec_next.memorySelectWindowAWide =
            defBytes_reg[`CFG_B_WA_CTL][`CFG_WIDE_BIT];
          dec_next.memorySelectWindowAAen =
            defBytes_reg[`CFG_B_WA_CTL][`CFG_AEN_BIT];
          dec_next.memorySelectWindowBBase =
            {defBytes_reg[`CFG_B_WB_BHI], defBytes_reg[`CFG_B_WB_BLO]};
        end else begin
          // Channel number equals the code for every valid selection
          dec_next.dmaChannelASelectNone  = (dmaCode == `CFG_DMA_NONE);
          dec_next.dmaChannelASelectValid = (dmaCode != `CFG_DMA_NONE)
                                         && (dmaCode != `CFG_DMA_BAD1)
                                         && (dmaCode != `CFG_DMA_BAD2);
          dec_next.dmaChannelASelect      = dec_next.dmaChannelASelectValid ? dmaCode
                                                                            : 3'h0;
        end
        act_next = actSync_reg ? '0
                 : defBytes_reg[`CFG_B_ACT][`CFG_ACT_BITS-1:0];
        loaded_next = 1'b1;
        state_next  = eeprom_loader_pkg::LD_IDLE;
      end
      eeprom_loader_pkg::LD_IDFILL: begin
        if (consume) begin
          id_next  = {curByte, id_reg[8*`CFG_ID_BYTES-1:8]};
          ptr_next = ptr_reg + PTR_W'(1);
          if (ptr_reg == PTR_W'(`CFG_ID_LAST)) begin
            idOk_next  = 1'b1;
            state_next = eeprom_loader_pkg::LD_IDLE;
          end
        end
      end
      eeprom_loader_pkg::LD_RESGET: begin
        if (consume) begin
          res_next      = curByte;
          resValid_next = 1'b1;
          ptr_next      = ptr_reg + PTR_W'(1);
          state_next    = eeprom_loader_pkg::LD_IDLE;
        end
      end
      eeprom_loader_pkg::LD_IDLE: begin
        // In the configuration state, prefetch the next byte once the host has taken the last one
        if (configState && !resValid_next) begin
          state_next = eeprom_loader_pkg::LD_RESGET;
        end
      end
    endcase
    // Wake and isolation events, ignored while defaults are still loading; a reload request always acts
    if (loaded_reg) begin
      if (wakeMatch) begin
        ptr_next      = PTR_W'(`CFG_ID_FIRST);
        resValid_next = 1'b0;
        state_next    = eeprom_loader_pkg::LD_IDLE;
      end else if (enterIsolation) begin
        ptr_next      = PTR_W'(`CFG_ID_FIRST);
        idOk_next     = 1'b0;
        resValid_next = 1'b0;
        state_next    = eeprom_loader_pkg::LD_IDFILL;
      end
    end
    if (reloadReq) begin
      ptr_next      = PTR_W'(`CFG_PTR_RESET);
      loaded_next   = 1'b0;
      resValid_next = 1'b0;
      state_next    = eeprom_loader_pkg::LD_BOOT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg    <= eeprom_loader_pkg::LD_BOOT;
      ptr_reg      <= PTR_W'(`CFG_PTR_RESET);
      defBytes_reg <= '{default: 8'h00};
      id_reg       <= '0;
      res_reg      <= 8'h00;
      act_reg      <= '0;
      dec_reg      <= '0;
      resValid_reg <= 1'b0;
      loaded_reg   <= 1'b0;
      idOk_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ptr_reg      <= ptr_next;
      defBytes_reg <= defBytes_next;
      id_reg       <= id_next;
      res_reg      <= res_next;
      act_reg      <= act_next;
      dec_reg      <= dec_next;
      resValid_reg <= resValid_next;
      loaded_reg   <= loaded_next;
      idOk_reg     <= idOk_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  generate
    for (gi = 0; gi < `CFG_DEF_COUNT; gi++) begin : g_def
      assign defaultRegs[8*gi +: 8] = defBytes_reg[gi];
    end
  endgenerate

  assign resData        = res_reg;
  assign resValid       = resValid_reg;
  assign defaultsLoaded = loaded_reg;
  assign cfgDecode      = dec_reg;
  assign deviceActive   = act_reg;
  assign serialId       = id_reg;
  assign idLoaded       = idOk_reg;
  assign readPtr        = ptr_reg;

endmodule

// ===== testbench/ee_model.sv
// Behavioural four-wire serial EEPROM holding bit-reversed 16-bit words
`timescale 1ns/10ps

module ee_model (
  // Serial pins
  input  wire logic eeCs,
  input  wire logic eeSk,
  input  wire logic eeDi,
  output logic      eeDo
);
  logic [7:0]  mem [0:511];
  logic [10:0] inBits;
  logic [15:0] outWord;
  int          edgeCnt;

  // Byte pairs stored the way the device expects them
  function automatic logic [15:0] stored(input logic [7:0] wa);
    logic [15:0] w;
    w = {mem[{wa, 1'b1}], mem[{wa, 1'b0}]};
    return {<<{w}};
  endfunction

  initial begin
    eeDo    = 1'b0;
    edgeCnt = 0;
  end

  // Deselected line flips, so a stale bit never passes for data
  always @(negedge eeCs) begin
    edgeCnt <= 0;
    eeDo    <= ~eeDo;
  end

  always @(posedge eeSk) begin
    if (eeCs) begin
      edgeCnt <= edgeCnt + 1;
      inBits  <= {inBits[9:0], eeDi};
      if (edgeCnt == 10) begin
        outWord <= (inBits[9:7] == 3'h6) ? stored({inBits[6:0], eeDi}) : 16'hFFFF;
        eeDo    <= 1'b0;
      end else if (edgeCnt > 10) begin
        eeDo    <= outWord[15];
        outWord <= {outWord[14:0], 1'b0};
      end
    end
  end
endmodule

// ===== testbench/serial_eeprom_config_loader_asserts.sv
// Port-level checks of the EEPROM configuration loader
`timescale 1ns/10ps
`include "eeprom_loader_cfg.svh"

module serial_eeprom_config_loader_asserts #(
  parameter int ADDR_BITS = 8
) (
  input wire logic                        core_clk,
  input wire logic                        sys_rst,
  input wire logic                        eeCs,
  input wire logic                        eeSk,
  input wire logic                        eeDi,
  input wire logic                        reloadReq,
  input wire logic                        enterIsolation,
  input wire logic                        wakeValid,
  input wire logic [7:0]                  wakeCsn,
  input wire logic [7:0]                  cardCsn,
  input wire logic                        resTake,
  input wire logic [7:0]                  resData,
  input wire logic                        resValid,
  input wire logic                        defaultsLoaded,
  input wire logic [8*`CFG_DEF_COUNT-1:0] defaultRegs,
  input eeprom_loader_pkg::cfg_decode_t   cfgDecode,
  input wire logic                        idLoaded,
  input wire logic [ADDR_BITS:0]          readPtr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_skHigh;
    eeSk [*4] ##1 !eeSk;
  endsequence
  sequence s_wakeHit;
    wakeValid && wakeCsn != 8'h00 && wakeCsn == cardCsn && defaultsLoaded && !reloadReq;
  endsequence

  property p_resetState;
    $fell(sys_rst) |-> !eeCs && !resValid && !defaultsLoaded && readPtr == 9'h000;
  endproperty
  property p_startBit;
    $rose(eeCs) |-> eeDi;
  endproperty
  property p_skIdle;
    !eeCs |-> !eeSk;
  endproperty
  property p_skHalf;
    $rose(eeSk) |-> s_skHigh;
  endproperty
  property p_wakePtr;
    s_wakeHit |=> readPtr == 9'h01C && !resValid;
  endproperty
  property p_idPtr;
    $rose(idLoaded) |-> readPtr == 9'h025;
  endproperty
  property p_resHold;
    resValid && !resTake && !reloadReq && !wakeValid && !enterIsolation
      |=> resValid && $stable(resData);
  endproperty
  property p_resStep;
    $rose(resValid) |-> readPtr == $past(readPtr) + 1'b1;
  endproperty
  property p_modeBit;
    $rose(defaultsLoaded) |-> cfgDecode.memMode == defaultRegs[0]
      && cfgDecode.submode == defaultRegs[2:1];
  endproperty
  property p_dmaDecode;
    $rose(defaultsLoaded) && !defaultRegs[0] |-> cfgDecode.memorySelectWindowABase == 16'h0000
      && cfgDecode.dmaChannelASelectNone == (defaultRegs[30:28] == 3'h4);
  endproperty
  property p_memWin;
    $rose(defaultsLoaded) && defaultRegs[0] |-> cfgDecode.memorySelectWindowBBase
      == defaultRegs[63:48] && cfgDecode.memorySelectWindowAWide == defaultRegs[25];
  endproperty

  a_resetState: assert property (p_resetState) else $error("state not cleared by reset");
  a_startBit: assert property (p_startBit) else $error("read without start bit");
  a_skIdle: assert property (p_skIdle) else $error("serial clock while deselected");
  a_skHalf: assert property (p_skHalf) else $error("serial clock high time wrong");
  a_wakePtr: assert property (p_wakePtr) else $error("wake match left pointer");
  a_idPtr: assert property (p_idPtr) else $error("pointer not at resource start");
  a_resHold: assert property (p_resHold) else $error("resource byte dropped");
  a_resStep: assert property (p_resStep) else $error("pointer not advanced");
  a_modeBit: assert property (p_modeBit) else $error("mode decode wrong");
  a_dmaDecode: assert property (p_dmaDecode) else $error("DMA decode wrong");
  a_memWin: assert property (p_memWin) else $error("window decode wrong");
endmodule

bind serial_eeprom_config_loader serial_eeprom_config_loader_asserts #(
  .ADDR_BITS(ADDR_BITS)
) serial_eeprom_config_loader_asserts_inst (.*);

// ===== testbench/serial_eeprom_config_loader_tb_top.sv
// Testbench of the EEPROM configuration loader with an EEPROM model
`timescale 1ns/10ps
`include "eeprom_loader_cfg.svh"

module serial_eeprom_config_loader_tb_top;
  logic                           core_clk, sys_rst, eeCs, eeSk, eeDi, eeDo;
  logic                           activate_at_reset_pin_n, reloadReq, enterIsolation;
  logic                           wakeValid, configState, resTake, resValid;
  logic                           defaultsLoaded, idLoaded;
  logic [7:0]                     wakeCsn, cardCsn, resData;
  logic [8*`CFG_DEF_COUNT-1:0]    defaultRegs;
  eeprom_loader_pkg::cfg_decode_t cfgDecode;
  logic [3:0]                     deviceActive;
  logic [71:0]                    serialId;
  logic [8:0]                     readPtr;
  int                             mismatches, checksDone;

  serial_eeprom_config_loader serial_eeprom_config_loader_inst (.*);
  ee_model ee_model_inst (.*);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    checksDone++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Bounded wait, always past one edge so a just-driven event has landed
  task automatic waitFor(input int sel, input int words);
    int  n;
    int  seen;
    logic last;
    n = 0;
    seen = 0;
    last = eeCs;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (last === 1'b1 && eeCs === 1'b0) seen++;
      last = eeCs;
      if (n > 20000) begin
        chk(72'(n), 72'(0));
        giveVerdict();
      end
    end while (!((sel == 0 && defaultsLoaded === 1'b1) || (sel == 1 && idLoaded === 1'b1)
                 || (sel == 2 && resValid === 1'b1) || (sel == 3 && seen >= words)));
  endtask

  task automatic takeRes(input logic [7:0] exp);
    waitFor(2, 0);
    chk(72'(resData), 72'(exp));
    @(posedge core_clk);
    resTake <= 1'b1;
    @(posedge core_clk);
    resTake <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] csn, input int which);
    @(posedge core_clk);
    wakeCsn        <= csn;
    wakeValid      <= (which == 0);
    enterIsolation <= (which == 1);
    reloadReq      <= (which == 2);
    @(posedge core_clk);
    wakeValid      <= 1'b0;
    enterIsolation <= 1'b0;
    reloadReq      <= 1'b0;
  endtask

  function automatic eeprom_loader_pkg::cfg_decode_t expCfg();
    eeprom_loader_pkg::cfg_decode_t c;
    logic [2:0] code;
    logic [7:0] m [8];
    for (int i = 0; i < 8; i++) m[i] = ee_model_inst.mem[i];
    c = '0;
    code = m[3][6:4];
    c.memMode = m[0][0];
    c.submode = m[0][2:1];
    if (c.memMode) begin
      c.memorySelectWindowABase = {m[2], m[1]};
      c.memorySelectWindowAHigh = {m[5], m[4]};
      c.memorySelectWindowAWide = m[3][1];
      c.memorySelectWindowAAen  = m[3][2];
      c.memorySelectWindowBBase = {m[7], m[6]};
    end else begin
      c.dmaChannelASelectValid = !(code inside {3'h1, 3'h2, 3'h4});
      c.dmaChannelASelectNone  = (code == 3'h4);
      c.dmaChannelASelect      = c.dmaChannelASelectValid ? code : 3'h0;
    end
    return c;
  endfunction

  // ****************************************************************
  // Clock and sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    sys_rst = 1'b1;
    activate_at_reset_pin_n = 1'b0;
    {reloadReq, enterIsolation, wakeValid, configState, resTake} = 5'h00;
    wakeCsn = 8'h00;
    cardCsn = 8'h03;
    mismatches = 0;
    checksDone = 0;
    for (int i = 0; i < 512; i++) ee_model_inst.mem[i] = 8'(i * 29 + 3);
    ee_model_inst.mem[0] = 8'h05;
    ee_model_inst.mem[3] = 8'h06;
    ee_model_inst.mem[27] = 8'h0A;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    waitFor(0, 0);
    for (int i = 0; i < 28; i++) chk(72'(defaultRegs[8*i +: 8]), 72'(ee_model_inst.mem[i]));
    chk(72'(cfgDecode), 72'(expCfg()));
    chk(72'(deviceActive), 72'(4'hA));
    $display("test defaults done");
    pulse(8'h00, 1);
    waitFor(1, 0);
    for (int i = 0; i < 9; i++) chk(72'(serialId[8*i +: 8]), 72'(ee_model_inst.mem[28 + i]));
    chk(72'(readPtr), 72'(9'h025));
    @(posedge core_clk);
    configState <= 1'b1;
    for (int i = 37; i < 41; i++) takeRes(ee_model_inst.mem[i]);
    pulse(8'h05, 0);
    takeRes(ee_model_inst.mem[41]);
    pulse(8'h03, 0);
    for (int i = 28; i < 31; i++) takeRes(ee_model_inst.mem[i]);
    $display("test isolation and resource done");
    configState <= 1'b0;
    activate_at_reset_pin_n <= 1'b1;
    repeat (400) @(posedge core_clk);
    ee_model_inst.mem[0] = 8'h02;
    for (int c = 0; c < 8; c++) begin
      ee_model_inst.mem[3] = {1'b0, 3'(c), 4'h6};
      pulse(8'h00, 2);
      waitFor(3, 14);
      repeat (8) @(posedge core_clk);
      waitFor(0, 0);
      chk(72'(cfgDecode), 72'(expCfg()));
      chk(72'(deviceActive), 72'(4'h0));
    end
    $display("test dma decode done");
    giveVerdict();
  end
endmodule
